// *** dv/i2cev_slave.sv ***
// Purpose: behavioural two-wire slave facing the event block
// Assumes: pull-ups on both lines, so a released line reads high
// Notes: acks its own address only; sends one fixed byte on reads
`timescale 1ns/1ps
module i2cev_slave #(
    parameter logic [6:0] SLV = 7'h2a,
    parameter logic [7:0] RDATA = 8'hc5
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] last
);
    logic [7:0] sh;
    logic rd;
    logic adr;
    logic act;
    logic nack;
    int n;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        last = 8'h00;
        sh = 8'h00;
        {rd, adr, act, nack} = 4'h0;
        n = 0;
    end
    // ==========================================
    // framing: sda edges while scl is high
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        adr = 1'b1;
        n = 0;
    end
    always @(posedge sda) if (scl) begin
        act = 1'b0;
        sda_oe = 1'b0;
    end
    // ==========================================
    // bit engine
    always @(posedge scl) if (act) begin
        if (n < 8)
            sh = {sh[6:0], sda};
        else
            nack = sda;
        n = n + 1;
    end
    always @(negedge scl) if (act) begin
        if (n == 8) begin
            if (adr)
                rd = sh[0];
            if (!adr && !rd)
                last = sh;
            // read data: let go so the master can ack or nack
            sda_oe = adr ? (sh[7:1] == SLV) : !rd;
        end else if (n == 9) begin
            // a nack ends the read; never hold sda against a stop
            sda_oe = rd && (adr || !nack) && !RDATA[7];
            adr = 1'b0;
            n = 0;
            if (stretch) begin
                scl_oe = 1'b1;
                #300;
                scl_oe = 1'b0;
            end
        end else if (rd && !adr) begin
            sda_oe = !RDATA[7 - n];
        end
    end
endmodule

// *** dv/test_i2c_master_event_shortcut_irq.sv ***
// Purpose: self-checking bench of the event block
// Assumes: QDIV 4, so one scl bit lasts 80 ns
// Notes: event registers are polled over apb under a bound
`timescale 1ns/1ps
`include "i2cev_defs.svh"
module test_i2c_master_event_shortcut_irq;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq;
    logic s_scl_oe, s_sda_oe;
    logic stretch = 1'b0;
    logic [7:0] last;
    wire scl = ~(scl_oe | s_scl_oe);
    wire sda = ~(sda_oe | s_sda_oe);
    int num_errors = 0;
    int n_tests = 0;
    localparam int POS[6] = `I2CEV_IE_POS;
    localparam logic [11:0] EVS[6] = '{`I2CEV_EV_STOPPED_OFS,
        `I2CEV_EV_RXRDY_OFS, `I2CEV_EV_TXDONE_OFS, `I2CEV_EV_ERROR_OFS,
        `I2CEV_EV_BOUND_OFS, `I2CEV_EV_PAUSED_OFS};
    always #2.5 pclk = ~pclk;

    i2cev_top #(.QDIV(4)) i_i2cev_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    i2cev_slave i_i2cev_slave (.scl(scl), .sda(sda), .stretch(stretch),
        .scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .last(last));

    // ==========================================
    // bus cycles and comparison
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait-state count assumed; the watchdog bounds a hang
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic chk(input string nm, input logic [31:0] x,
            input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // polls only when a set bit is expected
    task automatic ev(input string nm, input logic [11:0] a, input logic v);
        logic [31:0] r;
        int k;
        rd(a, r);
        for (k = 0; k < 3000 && v && r[0] !== 1'b1; k++)
            rd(a, r);
        chk(nm, {31'h0, v}, r);
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge pclk);
        chk("irq", {31'h0, v}, {31'h0, irq});
    endtask
    task automatic clr_ev();
        int i;
        for (i = 0; i < 6; i++)
            wr(EVS[i], 32'h1);
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        int i;
        for (i = 0; i < 6; i++)
            ev("event reset", EVS[i], 1'b0);
        rd(`I2CEV_IE_SET, r);
        chk("enable reset", 32'h0, r);
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'hffff_ffff);
        rd(`I2CEV_EVENT_TASK_SHORTCUTS, r);
        chk("shortcut bits", 32'h3, r);
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'h0);
        apb(1'b0, 12'h7fc, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        chk("pin drive level", 32'h0, {30'h0, scl_o, sda_o});
    endtask
    task automatic t_ie();
        logic [31:0] r, acc;
        int i;
        acc = 32'h0;
        for (i = 0; i < 6; i++) begin
            wr(`I2CEV_IE_SET, 32'h1 << POS[i]);
            acc = acc | (32'h1 << POS[i]);
            rd(`I2CEV_IE_SET, r);
            chk("enable set", acc, r);
        end
        wr(`I2CEV_IE_SET, 32'h0);
        rd(`I2CEV_IE_CLR, r);
        chk("set with zero", acc, r);
        for (i = 0; i < 6; i++) begin
            wr(`I2CEV_IE_CLR, 32'h1 << POS[i]);
            acc = acc & ~(32'h1 << POS[i]);
            rd(`I2CEV_IE_CLR, r);
            chk("enable clear", acc, r);
        end
    endtask
    task automatic t_write();
        wr(`I2CEV_ADDR, 32'h2a);
        wr(`I2CEV_ENABLE, 32'h1);
        wr(`I2CEV_TXD, 32'h96);
        wr(`I2CEV_IE_SET, 32'h1 << POS[4]);
        wr(`I2CEV_TASK_TX, 32'h1);
        ev("tx done", `I2CEV_EV_TXDONE_OFS, 1'b1);
        ev("boundary on write", `I2CEV_EV_BOUND_OFS, 1'b1);
        chk("byte on wire", 32'h96, {24'h0, last});
        irq_is(1'b1);
        wr(`I2CEV_IE_CLR, 32'h1 << POS[4]);
        irq_is(1'b0);
        wr(`I2CEV_TASK_STOP, 32'h1);
        ev("stopped", `I2CEV_EV_STOPPED_OFS, 1'b1);
    endtask
    task automatic t_read_halt();
        clr_ev();
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'h2);
        wr(`I2CEV_TASK_RX, 32'h1);
        ev("halt stops", `I2CEV_EV_STOPPED_OFS, 1'b1);
        ev("no pause", `I2CEV_EV_PAUSED_OFS, 1'b0);
        ev("boundary on read", `I2CEV_EV_BOUND_OFS, 1'b1);
    endtask
    task automatic t_read_pause();
        logic [31:0] r;
        logic l;
        clr_ev();
        stretch <= 1'b1;
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'h1);
        wr(`I2CEV_IE_SET, 32'h1 << POS[5]);
        wr(`I2CEV_TASK_RX, 32'h1);
        ev("paused", `I2CEV_EV_PAUSED_OFS, 1'b1);
        ev("rx ready", `I2CEV_EV_RXRDY_OFS, 1'b1);
        rd(`I2CEV_RXD, r);
        chk("rx byte", 32'hc5, r);
        irq_is(1'b1);
        l = scl;
        repeat (40) @(posedge pclk);
        chk("scl held", {31'h0, l}, {31'h0, scl});
        ev("no stop while paused", `I2CEV_EV_STOPPED_OFS, 1'b0);
        clr_ev();
        wr(`I2CEV_IE_CLR, 32'h1 << POS[5]);
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'h2);
        wr(`I2CEV_TASK_RESUME, 32'h1);
        ev("resume stops", `I2CEV_EV_STOPPED_OFS, 1'b1);
        ev("boundary again", `I2CEV_EV_BOUND_OFS, 1'b1);
        ev("second byte", `I2CEV_EV_RXRDY_OFS, 1'b1);
        ev("pause consumed", `I2CEV_EV_PAUSED_OFS, 1'b0);
        stretch <= 1'b0;
    endtask
    task automatic t_nack();
        clr_ev();
        wr(`I2CEV_EVENT_TASK_SHORTCUTS, 32'h0);
        wr(`I2CEV_ADDR, 32'h3b);
        wr(`I2CEV_IE_SET, 32'h1 << POS[3]);
        wr(`I2CEV_TASK_TX, 32'h1);
        ev("address nack", `I2CEV_EV_ERROR_OFS, 1'b1);
        irq_is(1'b1);
        ev("stop after nack", `I2CEV_EV_STOPPED_OFS, 1'b1);
        wr(`I2CEV_EV_ERROR_OFS, 32'h1);
        irq_is(1'b0);
    endtask

    // ==========================================
    // sequence and watchdog
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ie();
        t_write();
        t_read_halt();
        t_read_pause();
        t_nack();
        summarize();
    end
    // the run needs well under 40000 cycles
    initial begin
        #300000;
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        summarize();
    end
endmodule

// *** verilog/i2cev_defs.svh ***
// Purpose: constants of the i2c master event block
// Assumes: 32-bit apb, byte addresses
// Notes: events and enables share one index order
// Operation
// - byte boundary event before every byte
// - paused event after read ack, if requested
// - paused event marks entry to paused state
// - boundary to pause shortcut triggers pause on reads only
// - boundary to halt shortcut triggers stop
// - set bit enables halted interrupt
// - set bit enables rx byte interrupt
// - set bit enables tx done interrupt
// - set bit enables error interrupt
// - set bit enables byte boundary interrupt
// - set bit enables paused interrupt
// - clear register bit disables interrupt
// - rx byte ready after each received byte
`ifndef I2CEV_DEFS_SVH
`define I2CEV_DEFS_SVH
// ==========================================
// register offsets
`define I2CEV_TASK_RX 12'h000
`define I2CEV_TASK_TX 12'h008
`define I2CEV_TASK_STOP 12'h014
`define I2CEV_TASK_PAUSE 12'h01c
`define I2CEV_TASK_RESUME 12'h020
`define I2CEV_EV_STOPPED_OFS 12'h104
`define I2CEV_EV_RXRDY_OFS 12'h108
`define I2CEV_EV_TXDONE_OFS 12'h11c
`define I2CEV_EV_ERROR_OFS 12'h124
`define I2CEV_EV_BOUND_OFS 12'h138
`define I2CEV_EV_PAUSED_OFS 12'h148
`define I2CEV_EVENT_TASK_SHORTCUTS 12'h200
`define I2CEV_IE_SET 12'h304
`define I2CEV_IE_CLR 12'h308
`define I2CEV_ENABLE 12'h500
`define I2CEV_RXD 12'h518
`define I2CEV_TXD 12'h51c
`define I2CEV_ADDR 12'h588
// ==========================================
// event index and enable bit positions
`define I2CEV_EV_STOPPED 0
`define I2CEV_EV_RXRDY 1
`define I2CEV_EV_TXDONE 2
`define I2CEV_EV_ERROR 3
`define I2CEV_EV_BOUND 4
`define I2CEV_EV_PAUSED 5
`define I2CEV_IE_POS '{1, 2, 7, 9, 14, 18}
`define I2CEV_SH_PAUSE 0
`define I2CEV_SH_HALT 1
`define I2CEV_RESET_VAL 32'h0000_0000
// ==========================================
// timing: quarter of an scl period at 100 khz
`define I2CEV_CLK_NS 5
`define I2CEV_QUARTER_NS 2500
`define I2CEV_QUARTER_CYC (`I2CEV_QUARTER_NS / `I2CEV_CLK_NS)
`endif

// *** verilog/i2cev_pkg.sv ***
// Purpose: types of the i2c master event block
// Assumes: constants live in i2cev_defs.svh
// Notes: one packed struct holds all state except the two pin synchroniser stages
package i2cev_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_BYTE, S_WAIT, S_PAUSE, S_STOP
    } i2cev_st_t;

    typedef struct packed {
        i2cev_st_t st;
        logic [1:0] q;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rx;
        logic addr_ph;
        logic nack;
        logic [15:0] div;
        logic scl_lo;
        logic sda_lo;
        logic [5:0] ev;
        logic [5:0] ie;
        logic [1:0] event_task_shortcuts;
        logic [3:0] enable;
        logic [7:0] txd;
        logic txd_full;
        logic [7:0] rxd;
        logic [6:0] addr;
        logic stop_req;
        logic pause_req;
        logic [31:0] prdata;
        logic slverr;
        logic irq;
    } i2cev_state_t;
endpackage

// *** verilog/i2cev_sync.sv ***
// Purpose: two flop synchroniser for the bus pins
// Assumes: inputs are asynchronous to pclk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module i2cev_sync #(
    parameter int W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// *** verilog/i2cev_top.sv ***
// Purpose: i2c master with events, shortcuts and interrupts
// Assumes: open drain scl and sda, 200 mhz pclk
// Notes: zero wait apb slave, pready always high
`timescale 1ns/1ps
`include "i2cev_defs.svh"
module i2cev_top #(
    parameter int QDIV = `I2CEV_QUARTER_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    localparam int IE_POS [6] = `I2CEV_IE_POS;
    i2cev_pkg::i2cev_state_t s, n;
    logic scl_s, sda_s, tick, wr, en, byte_go, byte_end;
    logic go_rx, go_tx, t_stop, t_pause, t_resume, tx_next, go_stop, hit;
    logic [5:0] set_ev, clr_ev;
    logic [31:0] rdv;
    // ==========================================
    // enable layout helpers
    function automatic logic [31:0] ie_word(input logic [5:0] v);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i < 6; i++) begin
            w[IE_POS[i]] = v[i];
        end
        return w;
    endfunction
    function automatic logic [5:0] ie_bits(input logic [31:0] w);
        logic [5:0] v;
        v = '0;
        for (int i = 0; i < 6; i++) begin
            v[i] = w[IE_POS[i]];
        end
        return v;
    endfunction
    function automatic logic [31:0] ev_word(input logic b);
        return {31'h0, b};
    endfunction
    // ==========================================
    // pin synchronisers
    i2cev_sync #(.W(2)) i_i2cev_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({scl_i, sda_i}),
        .q({scl_s, sda_s})
    );
    // ==========================================
    // read decode
    always_comb begin
        rdv = `I2CEV_RESET_VAL;
        hit = 1'b1;
        case (paddr)
            `I2CEV_TASK_RX, `I2CEV_TASK_TX, `I2CEV_TASK_STOP,
            `I2CEV_TASK_PAUSE, `I2CEV_TASK_RESUME: rdv = '0;
            `I2CEV_EV_STOPPED_OFS: rdv = ev_word(s.ev[`I2CEV_EV_STOPPED]);
            `I2CEV_EV_RXRDY_OFS: rdv = ev_word(s.ev[`I2CEV_EV_RXRDY]);
            `I2CEV_EV_TXDONE_OFS: rdv = ev_word(s.ev[`I2CEV_EV_TXDONE]);
            `I2CEV_EV_ERROR_OFS: rdv = ev_word(s.ev[`I2CEV_EV_ERROR]);
            `I2CEV_EV_BOUND_OFS: rdv = ev_word(s.ev[`I2CEV_EV_BOUND]);
            `I2CEV_EV_PAUSED_OFS: rdv = ev_word(s.ev[`I2CEV_EV_PAUSED]);
            `I2CEV_EVENT_TASK_SHORTCUTS: rdv = {30'h0, s.event_task_shortcuts};
            `I2CEV_IE_SET, `I2CEV_IE_CLR: rdv = ie_word(s.ie);
            `I2CEV_ENABLE: rdv = {28'h0, s.enable};
            `I2CEV_RXD: rdv = {24'h0, s.rxd};
            `I2CEV_TXD: rdv = {24'h0, s.txd};
            `I2CEV_ADDR: rdv = {25'h0, s.addr};
            default: hit = 1'b0;
        endcase
    end
    // ==========================================
    // next state
    always_comb begin
        n = s;
        set_ev = '0;
        clr_ev = '0;
        byte_go = 1'b0;
        byte_end = 1'b0;
        tx_next = 1'b0;
        go_stop = 1'b0;
        wr = psel & penable & pwrite;
        en = s.enable != 4'h0;
        tick = s.div == 16'(QDIV - 1);
        n.div = tick ? 16'h0 : s.div + 16'h1;
        go_rx = wr && paddr == `I2CEV_TASK_RX && pwdata[0] && en;
        go_tx = wr && paddr == `I2CEV_TASK_TX && pwdata[0] && en;
        t_stop = wr && paddr == `I2CEV_TASK_STOP && pwdata[0];
        t_pause = wr && paddr == `I2CEV_TASK_PAUSE && pwdata[0];
        t_resume = wr && paddr == `I2CEV_TASK_RESUME && pwdata[0];
        n.stop_req = s.stop_req | t_stop;
        n.pause_req = s.pause_req | t_pause;
        // capture read data in setup so it is a flop in access
        if (psel && !penable) begin
            n.prdata = rdv;
            n.slverr = !hit;
        end
        case (s.st)
            i2cev_pkg::S_IDLE: begin
                n.scl_lo = 1'b0;
                n.sda_lo = 1'b0;
                if (go_rx || go_tx) begin
                    n.rx = go_rx;
                    n.st = i2cev_pkg::S_START;
                    n.q = 2'h0;
                    n.stop_req = 1'b0;
                    n.pause_req = 1'b0;
                end
            end
            i2cev_pkg::S_START: begin
                if (tick) begin
                    if (s.q == 2'h0) begin
                        n.sda_lo = 1'b1;
                        n.q = 2'h1;
                    end else begin
                        n.scl_lo = 1'b1;
                        n.addr_ph = 1'b1;
                        n.sh = {s.addr, s.rx};
                        byte_go = 1'b1;
                    end
                end
            end
            i2cev_pkg::S_BYTE: begin
                if (tick) begin
                    case (s.q)
                        2'h0: begin
                            n.scl_lo = 1'b1;
                            if (s.bitn != 4'h8) begin
                                n.sda_lo = (!s.rx || s.addr_ph) && !s.sh[7];
                            end else begin
                                // master acks a read byte unless it is last
                                n.sda_lo = s.rx && !s.addr_ph && !s.stop_req;
                            end
                            n.q = 2'h1;
                        end
                        2'h1: begin
                            n.scl_lo = 1'b0;
                            n.q = 2'h2;
                        end
                        2'h2: begin
                            // slave may stretch: wait for scl to rise
                            if (scl_s) begin
                                if (s.bitn != 4'h8) begin
                                    n.sh = {s.sh[6:0], sda_s};
                                end else begin
                                    n.nack = sda_s;
                                end
                                n.q = 2'h3;
                            end
                        end
                        2'h3: begin
                            n.scl_lo = 1'b1;
                            if (s.bitn != 4'h8) begin
                                n.bitn = s.bitn + 4'h1;
                                n.q = 2'h0;
                            end else begin
                                byte_end = 1'b1;
                            end
                        end
                        default: n.q = 2'h0;
                    endcase
                end
                if (byte_end) begin
                    n.sda_lo = 1'b0;
                    if (s.addr_ph) begin
                        n.addr_ph = 1'b0;
                        if (s.nack) begin
                            set_ev[`I2CEV_EV_ERROR] = 1'b1;
                            go_stop = 1'b1;
                        end else if (s.rx) begin
                            byte_go = 1'b1;
                        end else begin
                            tx_next = 1'b1;
                        end
                    end else if (!s.rx) begin
                        if (s.nack) begin
                            set_ev[`I2CEV_EV_ERROR] = 1'b1;
                            go_stop = 1'b1;
                        end else begin
                            set_ev[`I2CEV_EV_TXDONE] = 1'b1;
                            tx_next = 1'b1;
                        end
                    end else begin
                        set_ev[`I2CEV_EV_RXRDY] = 1'b1;
                        n.rxd = s.sh;
                        if (n.stop_req) begin
                            go_stop = 1'b1;
                        end else if (n.pause_req) begin
                            n.st = i2cev_pkg::S_PAUSE;
                            n.pause_req = 1'b0;
                            set_ev[`I2CEV_EV_PAUSED] = 1'b1;
                        end else begin
                            byte_go = 1'b1;
                        end
                    end
                end
            end
            i2cev_pkg::S_WAIT: begin
                tx_next = 1'b1;
            end
            i2cev_pkg::S_PAUSE: begin
                // scl held low while paused
                go_stop = n.stop_req;
                byte_go = !n.stop_req && t_resume;
            end
            i2cev_pkg::S_STOP: begin
                if (tick) begin
                    case (s.q)
                        2'h0: begin
                            n.sda_lo = 1'b1;
                            n.scl_lo = 1'b1;
                            n.q = 2'h1;
                        end
                        2'h1: begin
                            n.scl_lo = 1'b0;
                            n.q = 2'h2;
                        end
                        2'h2: n.q = scl_s ? 2'h3 : 2'h2;
                        default: begin
                            n.sda_lo = 1'b0;
                            n.st = i2cev_pkg::S_IDLE;
                            n.stop_req = 1'b0;
                            n.pause_req = 1'b0;
                            set_ev[`I2CEV_EV_STOPPED] = 1'b1;
                        end
                    endcase
                end
            end
            default: n.st = i2cev_pkg::S_IDLE;
        endcase
        if (tx_next) begin
            if (n.stop_req) begin
                go_stop = 1'b1;
            end else if (s.txd_full) begin
                n.sh = s.txd;
                n.txd_full = 1'b0;
                byte_go = 1'b1;
            end else begin
                n.st = i2cev_pkg::S_WAIT;
            end
        end
        if (go_stop) begin
            n.st = i2cev_pkg::S_STOP;
            n.q = 2'h0;
        end
        if (byte_go) begin
            n.st = i2cev_pkg::S_BYTE;
            n.bitn = 4'h0;
            n.q = 2'h0;
            set_ev[`I2CEV_EV_BOUND] = 1'b1;
            n.pause_req = n.pause_req | s.event_task_shortcuts[`I2CEV_SH_PAUSE];
            n.stop_req = n.stop_req | s.event_task_shortcuts[`I2CEV_SH_HALT];
        end
        if (!en) begin
            // disabling drops the bus at once, no stop sent
            n.st = i2cev_pkg::S_IDLE;
            n.scl_lo = 1'b0;
            n.sda_lo = 1'b0;
        end
        // ==========================================
        // register writes
        if (wr) begin
            case (paddr)
                `I2CEV_EV_STOPPED_OFS: clr_ev[`I2CEV_EV_STOPPED] = pwdata[0];
                `I2CEV_EV_RXRDY_OFS: clr_ev[`I2CEV_EV_RXRDY] = pwdata[0];
                `I2CEV_EV_TXDONE_OFS: clr_ev[`I2CEV_EV_TXDONE] = pwdata[0];
                `I2CEV_EV_ERROR_OFS: clr_ev[`I2CEV_EV_ERROR] = pwdata[0];
                `I2CEV_EV_BOUND_OFS: clr_ev[`I2CEV_EV_BOUND] = pwdata[0];
                `I2CEV_EV_PAUSED_OFS: clr_ev[`I2CEV_EV_PAUSED] = pwdata[0];
                `I2CEV_EVENT_TASK_SHORTCUTS: n.event_task_shortcuts = pwdata[1:0];
                `I2CEV_IE_SET: n.ie = s.ie | ie_bits(pwdata);
                `I2CEV_IE_CLR: n.ie = s.ie & ~ie_bits(pwdata);
                `I2CEV_ENABLE: n.enable = pwdata[3:0];
                `I2CEV_TXD: begin
                    n.txd = pwdata[7:0];
                    n.txd_full = 1'b1;
                end
                `I2CEV_ADDR: n.addr = pwdata[6:0];
                default: n.event_task_shortcuts = s.event_task_shortcuts;
            endcase
        end
        // hardware set wins over a software clear
        n.ev = (s.ev & ~clr_ev) | set_ev;
        n.irq = |(n.ev & n.ie);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
    // ==========================================
    // outputs
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s.slverr;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = s.scl_lo;
    assign sda_oe = s.sda_lo;
    assign irq = s.irq;
    // ==========================================
    // checks
    bnd_on_byte_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        byte_go |=> s.ev[`I2CEV_EV_BOUND] && s.bitn == 4'h0
    ) else $error("byte boundary event missing");
    paused_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(s.st == i2cev_pkg::S_PAUSE) |->
        s.rx && $past(s.bitn) == 4'h8 && s.ev[`I2CEV_EV_PAUSED]
    ) else $error("pause entered outside a read ack");
    paused_state_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(s.ev[`I2CEV_EV_PAUSED]) |-> s.st == i2cev_pkg::S_PAUSE
    ) else $error("paused event without paused state");
    short_pause_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        byte_go && s.event_task_shortcuts[`I2CEV_SH_PAUSE] |=> s.pause_req
    ) else $error("pause shortcut not taken");
    short_halt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        byte_go && s.event_task_shortcuts[`I2CEV_SH_HALT] && en |=> s.stop_req
    ) else $error("halt shortcut not taken");
    ie_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `I2CEV_IE_SET |=>
        (ie_word(s.ie) & $past(pwdata)) == ($past(pwdata) & ie_word(6'h3f))
    ) else $error("enable set did not take");
    ie_read_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == `I2CEV_IE_SET ##1 psel && penable
        |-> prdata == ie_word($past(s.ie))
    ) else $error("enable readback wrong");
    ie_clr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `I2CEV_IE_CLR |=>
        (ie_word(s.ie) & $past(pwdata)) == 32'h0
    ) else $error("enable clear did not take");
    rx_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        byte_end && s.rx && !s.addr_ph |=>
        s.ev[`I2CEV_EV_RXRDY] && s.rxd == $past(s.sh)
    ) else $error("rx byte ready missing");
    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s.ev & s.ie) != 6'h0 |-> irq ##1 ((s.ev & s.ie) == 6'h0 || irq)
    ) else $error("irq low with enabled event");
    set_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `I2CEV_IE_SET && pwdata == 32'h0 |=> $stable(s.ie)
    ) else $error("zero write changed enables");
endmodule
